// ### logic/upc_defs.vh
`ifndef UPC_DEFS_VH
`define UPC_DEFS_VH

`define UPC_ADDR_PWR        8'h3C
`define UPC_ADDR_PHY        8'h40

`define UPC_PWR_VALID_BIT   8
`define UPC_PWR_DATA_HI     7
`define UPC_PWR_DATA_LO     0

`define UPC_PHY_NOPD_BIT    18
`define UPC_PHY_RST_BIT     13
`define UPC_PHY_RES_BIT     12
`define UPC_PHY_FILT_HI     11
`define UPC_PHY_FILT_LO     8
`define UPC_PHY_AUTO_BIT    7
`define UPC_PHY_CONF_HI     6
`define UPC_PHY_CONF_LO     4

`define UPC_PWR_RESET       9'h000
`define UPC_PHY_RESET       32'h00000000

`define UPC_LS_SE0          2'h0
`define UPC_LS_J            2'h1
`define UPC_LS_K            2'h2

`endif

// ### logic/upc_phy_ctrl.v
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`include "upc_defs.vh"
`default_nettype none

module upc_phy_ctrl #(
  parameter FILT_W = 4,
  parameter CNT_W  = 16
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [1:0]  line_state_i,
  input  wire        suspended_i,
  output reg  [1:0]  line_state_filt_o,
  output reg         resume_o,
  output reg  [2:0]  phy_config_pins_o,
  output reg         usb_byte_port_a_pd_off_o,
  output reg         usb_byte_port_b_pd_off_o,
  output reg         pwr_valid_o,
  output reg  [7:0]  pwr_data_o
);

  // lane numbers
  localparam LANE_LO  = 0;
  localparam LANE_MID = 1;
  localparam LANE_HI  = 2;

  reg  [8:0]        pwr_reg;
  reg               nopd;
  reg               rst_flag;
  reg               res_flag;
  reg  [FILT_W-1:0] filt_exp;
  reg               auto_res;
  reg  [2:0]        conf;
  reg  [1:0]        ls_cand;
  reg  [CNT_W-1:0]  ls_cnt;
  reg  [1:0]        ls_filt;
  reg               hit_pwr;
  reg               hit_phy;
  reg  [31:0]       next_rdata;
  wire [CNT_W-1:0]  ls_one;
  wire [CNT_W-1:0]  ls_need;
  wire [CNT_W-1:0]  ls_cnt_inc;
  wire              ls_moved;
  wire              ls_hold;
  wire              req;
  wire              rd_req;
  wire              wr;
  wire              wr_pwr;
  wire              wr_phy;
  wire              clr_rst;
  wire              clr_res;
  wire              wake_arm;
  wire              wake_se0;
  wire              wake_k;
  wire              wake_any;

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_req     = req & ~wb_we_i;
  assign wr         = req & wb_we_i;
  assign wr_pwr     = wr & hit_pwr;
  assign wr_phy     = wr & hit_phy;
  assign clr_rst    = wr_phy & wb_sel_i[LANE_MID] & ~wb_dat_i[`UPC_PHY_RST_BIT];
  assign clr_res    = wr_phy & wb_sel_i[LANE_MID] & ~wb_dat_i[`UPC_PHY_RES_BIT];
  assign ls_one     = {{(CNT_W-1){1'b0}}, 1'b1};
  assign ls_need    = ls_one << filt_exp;
  assign ls_cnt_inc = ls_cnt + ls_one;
  assign ls_moved   = (line_state_i != ls_cand);
  assign ls_hold    = (ls_cnt < ls_need);
  assign wake_arm   = auto_res & suspended_i;
  assign wake_se0   = wake_arm & (ls_filt == `UPC_LS_SE0);
  assign wake_k     = wake_arm & (ls_filt == `UPC_LS_K);
  assign wake_any   = wake_se0 | wake_k;

  // address decode
  always @* begin
    hit_pwr = 1'b0;
    hit_phy = 1'b0;
    if (wb_adr_i == `UPC_ADDR_PWR) begin
      hit_pwr = 1'b1;
    end else if (wb_adr_i == `UPC_ADDR_PHY) begin
      hit_phy = 1'b1;
    end
  end

  // read mux
  always @* begin
    next_rdata = 32'h00000000;
    if (hit_pwr) begin
      next_rdata[`UPC_PWR_VALID_BIT]                = pwr_reg[8];
      next_rdata[`UPC_PWR_DATA_HI:`UPC_PWR_DATA_LO] = pwr_reg[7:0];
    end else if (hit_phy) begin
      next_rdata[`UPC_PHY_NOPD_BIT]                    = nopd;
      next_rdata[`UPC_PHY_RST_BIT]                     = rst_flag;
      next_rdata[`UPC_PHY_RES_BIT]                     = res_flag;
      next_rdata[`UPC_PHY_FILT_HI:`UPC_PHY_FILT_LO]    = filt_exp;
      next_rdata[`UPC_PHY_AUTO_BIT]                    = auto_res;
      next_rdata[`UPC_PHY_CONF_HI:`UPC_PHY_CONF_LO]    = conf;
    end
  end

  // ack, one cycle after the request is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read data, zero outside an ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_req) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= 32'h00000000;
    end
  end

  // power signalling word
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg <= `UPC_PWR_RESET;
    end else if (wr_pwr) begin
      if (wb_sel_i[LANE_LO]) begin
        pwr_reg[7:0] <= wb_dat_i[`UPC_PWR_DATA_HI:`UPC_PWR_DATA_LO];
      end
      if (wb_sel_i[LANE_MID]) begin
        pwr_reg[8] <= wb_dat_i[`UPC_PWR_VALID_BIT];
      end
    end
  end

  // pulldown disable
  always @(posedge clk_i) begin
    if (rst_i) begin
      nopd <= 1'b0;
    end else if (wr_phy && wb_sel_i[LANE_HI]) begin
      nopd <= wb_dat_i[`UPC_PHY_NOPD_BIT];
    end
  end

  // filter exponent
  always @(posedge clk_i) begin
    if (rst_i) begin
      filt_exp <= {FILT_W{1'b0}};
    end else if (wr_phy && wb_sel_i[LANE_MID]) begin
      filt_exp <= wb_dat_i[`UPC_PHY_FILT_HI:`UPC_PHY_FILT_LO];
    end
  end

  // hardware resume enable
  always @(posedge clk_i) begin
    if (rst_i) begin
      auto_res <= 1'b0;
    end else if (wr_phy && wb_sel_i[LANE_LO]) begin
      auto_res <= wb_dat_i[`UPC_PHY_AUTO_BIT];
    end
  end

  // phy config field
  always @(posedge clk_i) begin
    if (rst_i) begin
      conf <= 3'h0;
    end else if (wr_phy && wb_sel_i[LANE_LO]) begin
      conf <= wb_dat_i[`UPC_PHY_CONF_HI:`UPC_PHY_CONF_LO];
    end
  end

  // se0 wake cause, set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_flag <= 1'b0;
    end else if (wake_se0) begin
      rst_flag <= 1'b1;
    end else if (clr_rst) begin
      rst_flag <= 1'b0;
    end
  end

  // k wake cause, set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      res_flag <= 1'b0;
    end else if (wake_k) begin
      res_flag <= 1'b1;
    end else if (clr_res) begin
      res_flag <= 1'b0;
    end
  end

  // candidate line state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ls_cand <= `UPC_LS_J;
    end else if (ls_moved) begin
      ls_cand <= line_state_i;
    end
  end

  // persistence counter, saturates at the need
  always @(posedge clk_i) begin
    if (rst_i) begin
      ls_cnt <= {CNT_W{1'b0}};
    end else if (ls_moved) begin
      ls_cnt <= ls_one;
    end else if (ls_hold) begin
      ls_cnt <= ls_cnt_inc;
    end
  end

  // accepted line state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ls_filt <= `UPC_LS_J;
    end else if (ls_moved && (ls_need == ls_one)) begin
      ls_filt <= line_state_i;
    end else if (!ls_moved && ls_hold && (ls_cnt_inc == ls_need)) begin
      ls_filt <= ls_cand;
    end
  end

  // filtered line state out
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_state_filt_o <= `UPC_LS_J;
    end else begin
      line_state_filt_o <= ls_filt;
    end
  end

  // resume strobe out
  always @(posedge clk_i) begin
    if (rst_i) begin
      resume_o <= 1'b0;
    end else begin
      resume_o <= wake_any;
    end
  end

  // config pins out
  always @(posedge clk_i) begin
    if (rst_i) begin
      phy_config_pins_o <= 3'h0;
    end else begin
      phy_config_pins_o <= conf;
    end
  end

  // port a pulldown off
  always @(posedge clk_i) begin
    if (rst_i) begin
      usb_byte_port_a_pd_off_o <= 1'b0;
    end else begin
      usb_byte_port_a_pd_off_o <= nopd;
    end
  end

  // port b pulldown off
  always @(posedge clk_i) begin
    if (rst_i) begin
      usb_byte_port_b_pd_off_o <= 1'b0;
    end else begin
      usb_byte_port_b_pd_off_o <= nopd;
    end
  end

  // power valid out
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_valid_o <= 1'b0;
    end else begin
      pwr_valid_o <= pwr_reg[8];
    end
  end

  // power data out
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_data_o <= 8'h00;
    end else begin
      pwr_data_o <= pwr_reg[7:0];
    end
  end

endmodule

`default_nettype wire

// ### verification/upc_phy_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module upc_chk (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic        suspended_i, resume_o,
  input wire logic        usb_byte_port_a_pd_off_o, usb_byte_port_b_pd_off_o,
  input wire logic [7:0]  wb_adr_i, pwr_data_o,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [1:0]  line_state_i, line_state_filt_o,
  input wire logic [2:0]  phy_config_pins_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wp = wb_ack_o && wb_we_i && wb_adr_i == 8'h40;
  a_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack hold");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
  a_pd_write: assert property (wp && wb_sel_i[2] |=>
    usb_byte_port_a_pd_off_o == $past(wb_dat_i[18]) &&
    usb_byte_port_b_pd_off_o == usb_byte_port_a_pd_off_o) else $error("pd");
  a_conf_write: assert property (wp && wb_sel_i[0] |=>
    phy_config_pins_o == $past(wb_dat_i[6:4])) else $error("conf");
  a_filt_src: assert property ($changed(line_state_filt_o) |->
    line_state_filt_o == $past(line_state_i, 2)) else $error("filt");
  a_wake_line: assert property (resume_o |->
    $past(suspended_i) && line_state_filt_o != 2'h1) else $error("wake");
  a_pwr_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h3C && wb_sel_i[0]
    |=> pwr_data_o == $past(wb_dat_i[7:0])) else $error("pwr");
endmodule
bind upc_phy_ctrl upc_chk i_chk (.*);
`default_nettype wire

// ### verification/upc_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module upc_phy_model (
  input  wire logic       clk_i, go_i, resume_i,
  input  wire logic [1:0] ls_i,
  output logic      [1:0] line_state_o = 2'h1,
  output logic            suspended_o = 1'b0
);
  always @(posedge clk_i) begin
    line_state_o <= ls_i;
    if (resume_i)
      suspended_o <= 1'b0;
    else if (go_i)
      suspended_o <= 1'b1;
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0;
  logic        ack, res, susp, pa, pb, pv;
  logic [7:0]  adr = 8'h0, pd;
  logic [31:0] di = 32'h0, dout, c, b, q[$];
  logic [1:0]  ls = 2'h1, lsi, lsf;
  logic [2:0]  cf;
  logic [3:0]  sel = 4'hF;
  logic [15:0] r = 16'h43D6;
  int          error_cnt = 0, tests_run = 0, cycles = 0, n;
  upc_phy_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout),
    .wb_ack_o(ack), .line_state_i(lsi), .suspended_i(susp), .line_state_filt_o(lsf),
    .resume_o(res), .phy_config_pins_o(cf), .usb_byte_port_a_pd_off_o(pa),
    .usb_byte_port_b_pd_off_o(pb), .pwr_valid_o(pv), .pwr_data_o(pd));
  upc_phy_model i_phy (.clk_i(clk_i), .go_i(go), .resume_i(res), .ls_i(ls),
    .line_state_o(lsi), .suspended_o(susp));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    cyc <= 1'b1;
    sel <= s;
    we <= w;
    adr <= a;
    di <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (ack === 1'b1 && !we && q.size() > 0)
      chk(dout, q.pop_front());
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h3C, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    r = lfsr(r);
    wb(1'b1, 8'h3C, {16'hFFFF, r});
    rd(8'h3C, {23'h0, r[8:0]});
    chk({23'h0, pv, pd}, {23'h0, r[8:0]});
    c = 32'h00040080 | ({16'h0, r} & 32'h70);
    wb(1'b1, 8'h40, c | 32'hFFFBF00F);
    rd(8'h40, c);
    chk({29'h0, cf}, {29'h0, r[6:4]});
    chk({30'h0, pa, pb}, 32'h3);
    for (int k = 0; k < 2; k++) begin
      b = k ? 32'h2000 : 32'h1000;
      ls <= k ? 2'h0 : 2'h2;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      do @(posedge clk_i); while (res !== 1'b1);
      ls <= 2'h1;
      repeat (4) @(posedge clk_i);
      rd(8'h40, c | b);
      wb(1'b1, 8'h40, c);
      rd(8'h40, c);
    end
    wb(1'b1, 8'h40, 32'h0, 4'h4);
    rd(8'h40, c & 32'hFFFBFFFF);
    chk({30'h0, pa, pb}, 32'h0);
    wb(1'b1, 8'h40, c & 32'hFFFFFF7F | 32'h300);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    ls <= 2'h2;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      chk({31'h0, res}, 32'h0);
    end while (lsf !== 2'h2 && n < 40);
    chk(n, 11);
    give_verdict();
  end
endmodule
`default_nettype wire
